// [hw/lsg_gpio_ports.sv]
/*
  lsg_gpio_ports: seven general purpose ports, three of them shared with
  lcd segments, plus the com/segment shared pins.
  Assumes a cpu bus with one-cycle strobes, pads resolved outside from the
  output enables, and lcd, buzzer, pwm and key scan logic elsewhere.
*/
// Functional notes
// [R1] data registers load from write bus on strobe, return value on read
// [R2] register read returns latch, pin read returns synchronised pin level
// [R3] direction bit 1 makes pin output, 0 input, per pin
// [R4] reset clears all direction registers, pins start as inputs
// [R5] pull-up select 1 connects pull-up on ports a-d, active for inputs
// [R6] open-drain select 1 gives open drain, 0 push-pull, ports a-d
// [R7] port a function select resets to 0; 1 routes to alternate
// [R8] port a alternates: timer event, buzzer, two external interrupts
// [R9] port b function bit picks port or pulse width output, resets 0
// [R10] key scan mode overrides port d direction register
// [R11] port e drives segments 0-7 until select bit is 1
// [R12] port f drives segments 8-15 until select bit is 1
// [R13] port g input only, segments 16-23 until selected as port
// [R14] software writes segment selects before using shared pins as inputs
// [R15] lcd duty field switches shared pins between segment and common
// [R16] widths: a 4, b 1, c 6, d 4, e 8, f 8 bits
// [R17] port f data and direction reset to zero
// [R18] software writes write-only registers with whole bytes only
// [R19] unmapped and write-only addresses read zero, writes ignored
// [R20] pin inputs pass two flip-flops before reaching read bus
// [R21] alternate or segment use takes pad value and enable
`timescale 1ns/100ps
`default_nettype none
module lsg_gpio_ports (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // cpu register bus
  input wire logic [7:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_reg_in,
  input wire logic bus_rd_pin_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_rvalid_out,
  // pads, ports a to g
  input wire logic [7:0] pad_a_in,
  input wire logic [7:0] pad_b_in,
  input wire logic [7:0] pad_c_in,
  input wire logic [7:0] pad_d_in,
  input wire logic [7:0] pad_e_in,
  input wire logic [7:0] pad_f_in,
  input wire logic [7:0] pad_g_in,
  output logic [7:0] pad_a_out,
  output logic [7:0] pad_b_out,
  output logic [7:0] pad_c_out,
  output logic [7:0] pad_d_out,
  output logic [7:0] pad_e_out,
  output logic [7:0] pad_f_out,
  output logic [7:0] pad_g_out,
  output logic [7:0] pad_a_oe_n_out,
  output logic [7:0] pad_b_oe_n_out,
  output logic [7:0] pad_c_oe_n_out,
  output logic [7:0] pad_d_oe_n_out,
  output logic [7:0] pad_e_oe_n_out,
  output logic [7:0] pad_f_oe_n_out,
  output logic [7:0] pad_g_oe_n_out,
  output logic [7:0] pullup_a_out,
  output logic [7:0] pullup_b_out,
  output logic [7:0] pullup_c_out,
  output logic [7:0] pullup_d_out,
  // peripheral side
  input wire logic buzzer_output_in,
  input wire logic pulse_width_output_in,
  input wire logic key_scan_en_in,
  input wire logic [3:0] key_scan_dir_in,
  output logic timer_event_input_out,
  output logic ext_interrupt_a_out,
  output logic ext_interrupt_b_out,
  // lcd side
  input wire logic [23:0] lcd_seg_in,
  input wire logic [2:0] lcd_com_in,
  input wire logic [2:0] lcd_seg_hi_in,
  input wire logic [1:0] lcd_duty_field_in,
  output logic [2:0] com_seg_out
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [6:0][7:0] port_data, next_data;
  logic [6:0][7:0] port_dir, next_dir;
  logic [6:0][7:0] port_od, next_od;
  logic [6:0][7:0] port_pu, next_pu;
  logic [6:0][7:0] port_psr, next_psr;
  logic [7:0] func_a, next_func_a;
  logic [7:0] func_b, next_func_b;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [6:0][7:0] sync1, sync2, next_sync1, next_sync2;
  logic [6:0][7:0] pad_out_q, next_pad_out;
  logic [6:0][7:0] pad_oe_n_q, next_oe_n;
  logic [3:0][7:0] pullup_q, next_pullup;
  logic next_timer_event, next_int_a, next_int_b;
  logic [2:0] next_com_seg;
  logic [6:0][7:0] pad_all;
  logic [7:0] key_dir8;

  function automatic logic is_common(input logic [1:0] duty, input int k);
    is_common = (duty > 2'(k));
  endfunction

  assign pad_all = {pad_g_in, pad_f_in, pad_e_in, pad_d_in,
                    pad_c_in, pad_b_in, pad_a_in};
  assign key_dir8 = {key_scan_dir_in, 4'h0};

  // ***************************************************************
  // register file and read path
  // ***************************************************************
  always_comb begin
    next_data = port_data;
    next_dir = port_dir;
    next_od = port_od;
    next_pu = port_pu;
    next_psr = port_psr;
    next_func_a = func_a;
    next_func_b = func_b;
    next_rdata = bus_rdata_out;
    next_rvalid = 1'b0;
    if (bus_wr_in) begin
      for (int i = 0; i < lsg_pkg::NUM_RW_PORTS; i++) begin
        // [R1] data load
        if (bus_addr_in == lsg_pkg::ADDR_DATA[i]) begin
          next_data[i] = bus_wdata_in & lsg_pkg::PORT_MASK[i];
        end
        if (bus_addr_in == lsg_pkg::ADDR_DIR[i]) begin
          next_dir[i] = bus_wdata_in & lsg_pkg::PORT_MASK[i];
        end
      end
      for (int i = 0; i < lsg_pkg::NUM_OD_PORTS; i++) begin
        if (bus_addr_in == lsg_pkg::ADDR_OD[i]) begin
          next_od[i] = bus_wdata_in & lsg_pkg::PORT_MASK[i];
        end
        if (bus_addr_in == lsg_pkg::ADDR_PU[i]) begin
          next_pu[i] = bus_wdata_in & lsg_pkg::PORT_MASK[i];
        end
      end
      for (int i = lsg_pkg::PORT_E; i < lsg_pkg::NUM_PORTS; i++) begin
        if (bus_addr_in == lsg_pkg::ADDR_PSR[i - lsg_pkg::PORT_E]) begin
          next_psr[i] = bus_wdata_in;
        end
      end
      if (bus_addr_in == lsg_pkg::ADDR_FUNC_A) begin
        next_func_a = bus_wdata_in & lsg_pkg::PORT_MASK[lsg_pkg::PORT_A];
      end
      if (bus_addr_in == lsg_pkg::ADDR_FUNC_B) begin
        next_func_b = bus_wdata_in & lsg_pkg::PORT_MASK[lsg_pkg::PORT_B];
      end
    end
    if (bus_rd_reg_in || bus_rd_pin_in) begin
      next_rvalid = 1'b1;
      // [R19] unmapped and write-only read zero
      next_rdata = lsg_pkg::READ_ZERO;
      for (int i = 0; i < lsg_pkg::NUM_PORTS; i++) begin
        // [R2] latch or pin
        if (bus_addr_in == lsg_pkg::ADDR_DATA[i]) begin
          if (bus_rd_reg_in && i < lsg_pkg::NUM_RW_PORTS) begin
            next_rdata = port_data[i];
          end else begin
            next_rdata = sync2[i] & lsg_pkg::PORT_MASK[i];
          end
        end
      end
      for (int i = lsg_pkg::PORT_E; i < lsg_pkg::NUM_PORTS; i++) begin
        if (bus_addr_in == lsg_pkg::ADDR_PSR[i - lsg_pkg::PORT_E]) begin
          next_rdata = port_psr[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // [R4] directions clear
      port_dir <= '{default: lsg_pkg::DIR_RST};
      // [R17] data clear
      port_data <= '{default: lsg_pkg::DATA_RST};
      port_od <= '{default: lsg_pkg::OD_RST};
      port_pu <= '{default: lsg_pkg::PU_RST};
      port_psr <= '{default: lsg_pkg::PSR_RST};
      // [R7] normal io at reset
      func_a <= lsg_pkg::FUNC_RST;
      func_b <= lsg_pkg::FUNC_RST;
      bus_rdata_out <= lsg_pkg::READ_ZERO;
      bus_rvalid_out <= 1'b0;
    end else begin
      port_dir <= next_dir;
      port_data <= next_data;
      port_od <= next_od;
      port_pu <= next_pu;
      port_psr <= next_psr;
      func_a <= next_func_a;
      func_b <= next_func_b;
      bus_rdata_out <= next_rdata;
      bus_rvalid_out <= next_rvalid;
    end
  end

  // ***************************************************************
  // pad drive, synchronisers and peripheral routing
  // ***************************************************************
  // pads are registered so every output is a flop; costs one cycle
  always_comb begin
    logic val;
    logic en;
    val = 1'b0;
    en = 1'b0;
    // [R20] two-stage synchroniser
    next_sync1 = pad_all;
    next_sync2 = sync1;
    next_pullup = '0;
    for (int i = 0; i < lsg_pkg::NUM_PORTS; i++) begin
      for (int b = 0; b < 8; b++) begin
        // [R3] direction picks drive
        val = port_data[i][b];
        en = port_dir[i][b];
        // [R10] key scan owns direction
        if (i == lsg_pkg::PORT_D && key_scan_en_in) begin
          en = key_dir8[b];
        end
        // [R8] buzzer alternate
        if (i == lsg_pkg::PORT_A && b == lsg_pkg::ALT_BUZZER_BIT &&
            func_a[b]) begin
          val = buzzer_output_in;
          en = 1'b1;
        end
        // [R9] pulse width alternate
        if (i == lsg_pkg::PORT_B && b == lsg_pkg::ALT_PWM_BIT &&
            func_b[b]) begin
          val = pulse_width_output_in;
          en = 1'b1;
        end
        // [R6] open drain only pulls low
        if (i < lsg_pkg::NUM_OD_PORTS && port_od[i][b]) begin
          en = en & ~val;
          val = 1'b0;
        end
        // [R11] [R12] [R13] [R21] segment drive
        if (i >= lsg_pkg::PORT_E && !port_psr[i][b]) begin
          val = lcd_seg_in[(i - lsg_pkg::PORT_E) * lsg_pkg::SEG_PER_PORT + b];
          en = 1'b1;
        end
        // [R16] unimplemented pins never drive
        en = en & lsg_pkg::PORT_MASK[i][b];
        val = val & lsg_pkg::PORT_MASK[i][b];
        next_pad_out[i][b] = val;
        next_oe_n[i][b] = ~en;
        // [R5] pull-up only while input
        if (i < lsg_pkg::NUM_OD_PORTS) begin
          next_pullup[i][b] = port_pu[i][b] & ~en &
                              lsg_pkg::PORT_MASK[i][b];
        end
      end
    end
    // [R8] input alternates gated by select
    next_timer_event = func_a[lsg_pkg::ALT_TIMER_BIT] &
                       sync2[lsg_pkg::PORT_A][lsg_pkg::ALT_TIMER_BIT];
    next_int_a = func_a[lsg_pkg::ALT_INT_A_BIT] &
                 sync2[lsg_pkg::PORT_A][lsg_pkg::ALT_INT_A_BIT];
    next_int_b = func_a[lsg_pkg::ALT_INT_B_BIT] &
                 sync2[lsg_pkg::PORT_A][lsg_pkg::ALT_INT_B_BIT];
    for (int k = 0; k < lsg_pkg::NUM_SHARED; k++) begin
      // [R15] duty picks common or segment
      next_com_seg[k] = is_common(lcd_duty_field_in, k) ?
                        lcd_com_in[k] : lcd_seg_hi_in[k];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      pad_out_q <= '0;
      pad_oe_n_q <= '1;
      pullup_q <= '0;
      timer_event_input_out <= 1'b0;
      ext_interrupt_a_out <= 1'b0;
      ext_interrupt_b_out <= 1'b0;
      com_seg_out <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      pad_out_q <= next_pad_out;
      pad_oe_n_q <= next_oe_n;
      pullup_q <= next_pullup;
      timer_event_input_out <= next_timer_event;
      ext_interrupt_a_out <= next_int_a;
      ext_interrupt_b_out <= next_int_b;
      com_seg_out <= next_com_seg;
    end
  end

  assign pad_a_out = pad_out_q[lsg_pkg::PORT_A];
  assign pad_b_out = pad_out_q[lsg_pkg::PORT_B];
  assign pad_c_out = pad_out_q[lsg_pkg::PORT_C];
  assign pad_d_out = pad_out_q[lsg_pkg::PORT_D];
  assign pad_e_out = pad_out_q[lsg_pkg::PORT_E];
  assign pad_f_out = pad_out_q[lsg_pkg::PORT_F];
  assign pad_g_out = pad_out_q[lsg_pkg::PORT_G];
  assign pad_a_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_A];
  assign pad_b_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_B];
  assign pad_c_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_C];
  assign pad_d_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_D];
  assign pad_e_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_E];
  assign pad_f_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_F];
  assign pad_g_oe_n_out = pad_oe_n_q[lsg_pkg::PORT_G];
  assign pullup_a_out = pullup_q[lsg_pkg::PORT_A];
  assign pullup_b_out = pullup_q[lsg_pkg::PORT_B];
  assign pullup_c_out = pullup_q[lsg_pkg::PORT_C];
  assign pullup_d_out = pullup_q[lsg_pkg::PORT_D];

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  data_write_a: assert property ( // [R1]
    bus_wr_in && bus_addr_in == lsg_pkg::ADDR_DATA[lsg_pkg::PORT_C]
    |=> port_data[lsg_pkg::PORT_C] ==
        ($past(bus_wdata_in) & lsg_pkg::PORT_MASK[lsg_pkg::PORT_C]))
    else $error("data write not stored");
  reg_read_a: assert property ( // [R2]
    bus_rd_reg_in && bus_addr_in == lsg_pkg::ADDR_DATA[lsg_pkg::PORT_F]
    |=> bus_rvalid_out && bus_rdata_out == $past(port_data[lsg_pkg::PORT_F]))
    else $error("register read wrong");
  pin_read_a: assert property ( // [R20]
    bus_rd_pin_in && !bus_rd_reg_in &&
    bus_addr_in == lsg_pkg::ADDR_DATA[lsg_pkg::PORT_F]
    |=> bus_rdata_out == $past(pad_f_in, 3))
    else $error("pin read not three cycles behind pad");
  dir_drive_a: assert property ( // [R3]
    port_od[lsg_pkg::PORT_C] == '0
    |=> pad_c_oe_n_out ==
        ~($past(port_dir[lsg_pkg::PORT_C]) & lsg_pkg::PORT_MASK[lsg_pkg::PORT_C]))
    else $error("direction not on enable");
  dir_reset_a: assert property (disable iff (1'b0) // [R4]
    rst_in |=> port_dir == '0 && func_a == '0)
    else $error("reset left direction or function set");
  pullup_input_a: assert property ( // [R5]
    port_pu[lsg_pkg::PORT_C][0] && !port_dir[lsg_pkg::PORT_C][0]
    |=> pullup_c_out[0])
    else $error("pull-up missing on input");
  open_drain_a: assert property ( // [R6]
    port_od[lsg_pkg::PORT_A][4] && port_data[lsg_pkg::PORT_A][4] &&
    !func_a[lsg_pkg::ALT_BUZZER_BIT] |=> pad_a_oe_n_out[4])
    else $error("open drain drove high");
  buzzer_route_a: assert property ( // [R8]
    func_a[lsg_pkg::ALT_BUZZER_BIT] && !port_od[lsg_pkg::PORT_A][4]
    |=> !pad_a_oe_n_out[4] && pad_a_out[4] == $past(buzzer_output_in))
    else $error("buzzer not routed");
  pwm_route_a: assert property ( // [R9]
    func_b[lsg_pkg::ALT_PWM_BIT] && !port_od[lsg_pkg::PORT_B][0]
    |=> !pad_b_oe_n_out[0] && pad_b_out[0] == $past(pulse_width_output_in))
    else $error("pulse width not routed");
  key_scan_a: assert property ( // [R10]
    key_scan_en_in && port_od[lsg_pkg::PORT_D] == '0
    |=> pad_d_oe_n_out[7:4] == ~$past(key_scan_dir_in))
    else $error("key scan direction ignored");
  segment_e_a: assert property ( // [R11]
    !port_psr[lsg_pkg::PORT_E][0]
    |=> !pad_e_oe_n_out[0] && pad_e_out[0] == $past(lcd_seg_in[0]))
    else $error("segment not on port e");
  input_only_a: assert property ( // [R13]
    port_psr[lsg_pkg::PORT_G][0] |=> pad_g_oe_n_out[0])
    else $error("port g drove in port use");
  shared_com_a: assert property ( // [R15]
    lcd_duty_field_in == 2'h3 |=> com_seg_out == $past(lcd_com_in))
    else $error("shared pins not commons");

  seg_release_c: cover property (
    !port_psr[lsg_pkg::PORT_F][0] ##1 port_psr[lsg_pkg::PORT_F][0]);
  int_a_c: cover property (ext_interrupt_a_out);
  pin_read_c: cover property (bus_rd_pin_in ##1 bus_rvalid_out);

endmodule
`default_nettype wire

// [hw/lsg_pkg.sv]
/*
  lsg_pkg: constants shared by the LCD-shared general purpose I/O block.
  Assumes an 8-bit CPU register bus with byte addresses in the control area.
*/
package lsg_pkg;
  // ***************************************************************
  // port indices and widths
  // ***************************************************************
  localparam int NUM_PORTS = 7;
  localparam int NUM_RW_PORTS = 6;
  localparam int NUM_OD_PORTS = 4;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;
  localparam int SEG_PER_PORT = 8;
  localparam int NUM_SEG = 24;
  localparam int NUM_SHARED = 3;
  localparam int DUTY_W = 2;
  localparam int KEY_SCAN_W = 4;
  localparam int KEY_SCAN_LSB = 4;
  // implemented pins per port, index 0 is port a
  localparam logic [6:0][7:0] PORT_MASK =
    {8'hff, 8'hff, 8'hff, 8'hf0, 8'h3f, 8'h01, 8'hd2};
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [6:0][7:0] ADDR_DATA =
    {8'hb0, 8'hcc, 8'hca, 8'hc6, 8'hc4, 8'hc2, 8'hc0};
  localparam logic [5:0][7:0] ADDR_DIR =
    {8'hcd, 8'hcb, 8'hc7, 8'hc5, 8'hc3, 8'hc1};
  localparam logic [3:0][7:0] ADDR_OD = {8'ha3, 8'ha2, 8'ha1, 8'ha0};
  localparam logic [3:0][7:0] ADDR_PU = {8'ha8, 8'ha7, 8'ha6, 8'ha5};
  localparam logic [7:0] ADDR_FUNC_A = 8'haa;
  localparam logic [7:0] ADDR_FUNC_B = 8'hab;
  localparam logic [2:0][7:0] ADDR_PSR = {8'hae, 8'had, 8'hac};
  // ***************************************************************
  // reset values and field positions
  // ***************************************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OD_RST = 8'h00;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [7:0] PSR_RST = 8'hff;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int ALT_TIMER_BIT = 1;
  localparam int ALT_BUZZER_BIT = 4;
  localparam int ALT_INT_A_BIT = 6;
  localparam int ALT_INT_B_BIT = 7;
  localparam int ALT_PWM_BIT = 0;
endpackage

// [hw/unused_placeholder_none.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [testbench/lsg_pad_model.sv]
/*
  lsg_pad_model: board side of the seven port pads, packed as arrays with
  index 0 for port a.
  Assumes active-low output enables from the block and a bench that never
  drives a pin the block is driving.
*/
`timescale 1ns/100ps
`default_nettype none
module lsg_pad_model (
  // clock
  input wire logic core_clk_in,
  // block side
  input wire logic [6:0][7:0] drive_val_in,
  input wire logic [6:0][7:0] oe_n_in,
  input wire logic [6:0][7:0] pull_in,
  // board side
  input wire logic [6:0][7:0] ext_val_in,
  input wire logic [6:0][7:0] ext_en_in,
  output logic [6:0][7:0] level_out
);
  // ***************************************************************
  // pin resolution
  // ***************************************************************
  // a floating pin toggles so a stale level can never pass for a match
  logic wander;
  initial wander = 1'b0;
  always @(posedge core_clk_in) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!oe_n_in[p][b]) begin
          level_out[p][b] = drive_val_in[p][b];
        end else if (ext_en_in[p][b]) begin
          level_out[p][b] = ext_val_in[p][b];
        end else if (pull_in[p][b]) begin
          level_out[p][b] = 1'b1;
        end else begin
          level_out[p][b] = wander;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
/*
  tb: self-checking bench for the lcd-shared port block.
  Assumes the pad model resolves pins and the bench acts as the cpu.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic core_clk_in, rst_in, bus_wr_in, bus_rd_reg_in, bus_rd_pin_in;
  logic bus_rvalid_out, buzzer_output_in, pulse_width_output_in;
  logic key_scan_en_in, timer_event_input_out;
  logic ext_interrupt_a_out, ext_interrupt_b_out;
  logic [7:0] bus_addr_in, bus_wdata_in, bus_rdata_out;
  logic [7:0] pad_a_in, pad_b_in, pad_c_in, pad_d_in, pad_e_in, pad_f_in;
  logic [7:0] pad_g_in, pad_a_out, pad_b_out, pad_c_out, pad_d_out;
  logic [7:0] pad_e_out, pad_f_out, pad_g_out, pad_a_oe_n_out;
  logic [7:0] pad_b_oe_n_out, pad_c_oe_n_out, pad_d_oe_n_out;
  logic [7:0] pad_e_oe_n_out, pad_f_oe_n_out, pad_g_oe_n_out;
  logic [7:0] pullup_a_out, pullup_b_out, pullup_c_out, pullup_d_out;
  logic [3:0] key_scan_dir_in;
  logic [23:0] lcd_seg_in;
  logic [2:0] lcd_com_in, lcd_seg_hi_in, com_seg_out;
  logic [1:0] lcd_duty_field_in;
  logic [6:0][7:0] ext_val, ext_en, level, oe_all, out_all;
  logic [5:0][7:0] mask;
  int miscompares, checks;
  assign {pad_g_in, pad_f_in, pad_e_in, pad_d_in, pad_c_in, pad_b_in,
    pad_a_in} = level;
  assign oe_all = {pad_g_oe_n_out, pad_f_oe_n_out, pad_e_oe_n_out,
    pad_d_oe_n_out, pad_c_oe_n_out, pad_b_oe_n_out, pad_a_oe_n_out};
  assign out_all = {pad_g_out, pad_f_out, pad_e_out, pad_d_out, pad_c_out,
    pad_b_out, pad_a_out};
  assign mask = {8'hff, 8'hff, 8'hf0, 8'h3f, 8'h01, 8'hd2};
  lsg_gpio_ports i_dut (.core_clk_in, .rst_in, .bus_addr_in,
    .bus_wdata_in, .bus_wr_in, .bus_rd_reg_in, .bus_rd_pin_in,
    .bus_rdata_out, .bus_rvalid_out, .pad_a_in, .pad_b_in, .pad_c_in,
    .pad_d_in, .pad_e_in, .pad_f_in, .pad_g_in, .pad_a_out, .pad_b_out,
    .pad_c_out, .pad_d_out, .pad_e_out, .pad_f_out, .pad_g_out,
    .pad_a_oe_n_out, .pad_b_oe_n_out, .pad_c_oe_n_out, .pad_d_oe_n_out,
    .pad_e_oe_n_out, .pad_f_oe_n_out, .pad_g_oe_n_out, .pullup_a_out,
    .pullup_b_out, .pullup_c_out, .pullup_d_out, .buzzer_output_in,
    .pulse_width_output_in, .key_scan_en_in, .key_scan_dir_in,
    .timer_event_input_out, .ext_interrupt_a_out, .ext_interrupt_b_out,
    .lcd_seg_in, .lcd_com_in, .lcd_seg_hi_in, .lcd_duty_field_in,
    .com_seg_out);
  lsg_pad_model i_pads (.core_clk_in, .drive_val_in(out_all),
    .oe_n_in(oe_all), .pull_in({24'h000000, pullup_d_out, pullup_c_out,
    pullup_b_out, pullup_a_out}), .ext_val_in(ext_val),
    .ext_en_in(ext_en), .level_out(level));
  // ***************************************************************
  // bus and check tasks
  // ***************************************************************
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task settle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    bus_addr_in = a;
    bus_wdata_in = d;
    bus_wr_in = 1'b1;
    @(negedge core_clk_in);
    bus_wr_in = 1'b0;
  endtask
  task rdchk(input string n, input logic [7:0] a, input logic pin,
    input logic [7:0] exp);
    @(negedge core_clk_in);
    bus_addr_in = a;
    bus_rd_reg_in = !pin;
    bus_rd_pin_in = pin;
    @(negedge core_clk_in);
    bus_rd_reg_in = 1'b0;
    bus_rd_pin_in = 1'b0;
    check("rvalid", {7'h00, bus_rvalid_out}, 8'h01);
    check(n, bus_rdata_out, exp);
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task t_reset;
    for (int i = 0; i < 6; i++) begin
      rdchk("data reset", lsg_pkg::ADDR_DATA[i], 1'b0, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      rdchk("select reset", lsg_pkg::ADDR_PSR[i], 1'b0, 8'hff);
    end
    for (int i = 0; i < 7; i++) begin
      check("oe_n reset", oe_all[i], 8'hff);
    end
    rdchk("write-only read", 8'hc1, 1'b0, 8'h00);
    rdchk("unmapped read", 8'ha4, 1'b0, 8'h00);
    $display("test reset done");
  endtask
  task t_data;
    for (int i = 0; i < 6; i++) begin
      wr(lsg_pkg::ADDR_DATA[i], 8'hff);
      rdchk("data", lsg_pkg::ADDR_DATA[i], 1'b0, mask[i]);
      wr(lsg_pkg::ADDR_DIR[i], 8'hff);
      settle(2);
      check("oe_n out", oe_all[i], ~mask[i]);
      check("pad out", out_all[i], mask[i]);
    end
    wr(8'hc5, 8'h15);
    settle(2);
    check("oe_n c", pad_c_oe_n_out, 8'hea);
    for (int i = 0; i < 6; i++) begin
      wr(lsg_pkg::ADDR_DIR[i], 8'h00);
      wr(lsg_pkg::ADDR_DATA[i], 8'h00);
    end
    $display("test data done");
  endtask
  task t_pin;
    wr(8'hc4, 8'h2a);
    ext_en[2] = 8'hff;
    ext_val[2] = 8'h15;
    settle(4);
    rdchk("pin c", 8'hc4, 1'b1, 8'h15);
    rdchk("reg c", 8'hc4, 1'b0, 8'h2a);
    ext_val[2] = 8'h2a;
    rdchk("pin c sync", 8'hc4, 1'b1, 8'h15);
    settle(4);
    rdchk("pin c new", 8'hc4, 1'b1, 8'h2a);
    ext_en[2] = 8'h00;
    wr(8'ha7, 8'hff);
    settle(4);
    check("pullup c", pullup_c_out, 8'h3f);
    rdchk("pin c pulled", 8'hc4, 1'b1, 8'h3f);
    wr(8'hc5, 8'hff);
    settle(2);
    check("pullup c out", pullup_c_out, 8'h00);
    wr(8'hc5, 8'h00);
    wr(8'ha7, 8'h00);
    $display("test pin done");
  endtask
  task t_od;
    wr(8'hc1, 8'hff);
    wr(8'hc0, 8'h10);
    wr(8'ha0, 8'hff);
    settle(2);
    check("od oe_n a", pad_a_oe_n_out, 8'h3d);
    check("od out a", pad_a_out, 8'h00);
    wr(8'ha0, 8'h00);
    settle(2);
    check("pp oe_n a", pad_a_oe_n_out, 8'h2d);
    check("pp out a", pad_a_out, 8'h10);
    wr(8'hc1, 8'h00);
    wr(8'hc0, 8'h00);
    $display("test open drain done");
  endtask
  task t_alt;
    wr(8'haa, 8'hff);
    buzzer_output_in = 1'b1;
    ext_en[0] = 8'hc2;
    ext_val[0] = 8'h42;
    settle(5);
    check("buzzer", {6'h00, pad_a_oe_n_out[4], pad_a_out[4]}, 8'h01);
    check("alt in", {5'h00, timer_event_input_out, ext_interrupt_a_out,
      ext_interrupt_b_out}, 8'h06);
    ext_val[0] = 8'h80;
    settle(5);
    check("alt in b", {5'h00, timer_event_input_out, ext_interrupt_a_out,
      ext_interrupt_b_out}, 8'h01);
    wr(8'haa, 8'h00);
    settle(5);
    check("alt off", {5'h00, timer_event_input_out, ext_interrupt_a_out,
      ext_interrupt_b_out}, 8'h00);
    check("buzzer off", {6'h00, pad_a_oe_n_out[4], pad_a_out[4]}, 8'h02);
    wr(8'hab, 8'h01);
    pulse_width_output_in = 1'b1;
    settle(2);
    check("pwm", {6'h00, pad_b_oe_n_out[0], pad_b_out[0]}, 8'h01);
    wr(8'hab, 8'h00);
    settle(2);
    check("pwm off", {6'h00, pad_b_oe_n_out[0], pad_b_out[0]}, 8'h02);
    buzzer_output_in = 1'b0;
    pulse_width_output_in = 1'b0;
    ext_en[0] = 8'h00;
    $display("test alternate done");
  endtask
  task t_key;
    key_scan_en_in = 1'b1;
    key_scan_dir_in = 4'ha;
    settle(2);
    check("key dir", pad_d_oe_n_out, 8'h5f);
    wr(8'hc7, 8'hf0);
    key_scan_dir_in = 4'h0;
    settle(2);
    check("key override", pad_d_oe_n_out, 8'hff);
    key_scan_en_in = 1'b0;
    wr(8'hc7, 8'h00);
    $display("test key scan done");
  endtask
  task t_seg;
    lcd_seg_in = 24'h5a3cc3;
    for (int i = 0; i < 3; i++) begin
      wr(lsg_pkg::ADDR_PSR[i], 8'h00);
    end
    settle(2);
    rdchk("select rw", 8'hac, 1'b0, 8'h00);
    check("seg e", pad_e_out, 8'hc3);
    check("seg f", pad_f_out, 8'h3c);
    check("seg g", pad_g_out, 8'h5a);
    check("seg oe_n", pad_e_oe_n_out | pad_f_oe_n_out | pad_g_oe_n_out,
      8'h00);
    rdchk("pin f seg", 8'hcc, 1'b1, 8'h3c);
    for (int d = 0; d < 4; d++) begin
      lcd_duty_field_in = 2'(d);
      settle(2);
      for (int k = 0; k < 3; k++) begin
        check("com seg", {7'h00, com_seg_out[k]},
          {7'h00, (d > k) ? lcd_com_in[k] : lcd_seg_hi_in[k]});
      end
    end
    // select port use before reading pins
    wr(8'hae, 8'hff);
    wr(8'hb0, 8'h00);
    ext_en[6] = 8'hff;
    ext_val[6] = 8'h96;
    settle(4);
    rdchk("pin g", 8'hb0, 1'b1, 8'h96);
    rdchk("reg g", 8'hb0, 1'b0, 8'h96);
    check("oe_n g", pad_g_oe_n_out, 8'hff);
    $display("test segment done");
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ***************************************************************
  // clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    miscompares++;
    print_verdict;
  end
  initial begin
    miscompares = 0;
    checks = 0;
    rst_in = 1'b1;
    {bus_wr_in, bus_rd_reg_in, bus_rd_pin_in} = 3'h0;
    bus_addr_in = 8'h00;
    bus_wdata_in = 8'h00;
    {buzzer_output_in, pulse_width_output_in, key_scan_en_in} = 3'h0;
    key_scan_dir_in = 4'h0;
    lcd_seg_in = 24'h000000;
    lcd_com_in = 3'h5;
    lcd_seg_hi_in = 3'h2;
    lcd_duty_field_in = 2'h0;
    ext_val = '0;
    ext_en = '0;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    t_reset;
    t_data;
    t_pin;
    t_od;
    t_alt;
    t_key;
    t_seg;
    print_verdict;
  end
endmodule
`default_nettype wire
